/* File: logic/fpm_map.svh */
/*
 Constants for the front panel menu controller: times, scaling, defaults.
 Assumes a 20 MHz system clock; include with `include "fpm_map.svh".
*/
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define FPM_CLK_KHZ 20000
`define FPM_INIT_MS 100
`define FPM_BLANK_MS 500
`define FPM_MINUS_MS 3000
`define FPM_SAVE_MS 2000
`define FPM_DEBOUNCE_MS 10
`define FPM_COMBO_MS 100
// ----------------------------------------
// scaling, input current in microamps
// ----------------------------------------
`define FPM_UA_4MA 18'sh00FA0
`define FPM_UA_SPAN 18'sh03E80
`define FPM_UA_ROOT_MIN 18'sh00028
`define FPM_UA_PER_CA 18'sh0000A
`define FPM_DEF_LO 18'sh00000
`define FPM_DEF_HI 18'sh02710
// ----------------------------------------
// defaults and limits
// ----------------------------------------
`define FPM_DEF_CODE 16'h0000
`define FPM_LAST_ITEM 3'h5
`define FPM_DP_MAX 3'h5
`define FPM_BCD_MAX 4'h9
`define FPM_LAST_DIGIT 2'h3
`endif

/* File: logic/fpm_pkg.sv */
/*
 Types of the front panel menu controller.
 Assumes nothing beyond the constants header.
*/
package fpm_pkg;
   typedef enum logic [3:0] {
      FPM_ST_INIT = 4'h0, FPM_ST_BLANK = 4'h1, FPM_ST_MINUS = 4'h2,
      FPM_ST_DISPLAY = 4'h3, FPM_ST_LOCK = 4'h4, FPM_ST_CODE = 4'h5,
      FPM_ST_MENU = 4'h6, FPM_ST_ITEM = 4'h7, FPM_ST_SAVE = 4'h8
   } fpm_state_t;
   typedef enum logic [2:0] {
      FPM_IT_ROOT = 3'h0, FPM_IT_NUM = 3'h1, FPM_IT_STEP = 3'h2,
      FPM_IT_PAD = 3'h3, FPM_IT_DP = 3'h4, FPM_IT_BAR = 3'h5
   } fpm_item_t;
   typedef enum logic [1:0] {
      FPM_STEP_1 = 2'h0, FPM_STEP_2 = 2'h1, FPM_STEP_5 = 2'h2, FPM_STEP_10 = 2'h3
   } fpm_step_t;
   typedef enum logic [1:0] {
      FPM_SHOW_VALUE = 2'h0, FPM_SHOW_LOCK = 2'h1, FPM_SHOW_CODE = 2'h2,
      FPM_SHOW_MENU = 2'h3
   } fpm_show_t;
endpackage : fpm_pkg

/* File: logic/fpm_debounce.sv */
/*
 Push-button debouncer: per button a two-stage synchroniser, a stability
 counter, a clean level and a one-cycle press pulse.
 Assumes raw inputs are active high and asynchronous to clk.
*/
`include "fpm_map.svh"
module fpm_debounce
   import fpm_pkg::*;
#(
   parameter int N = 4,
   parameter int CNT_W = 18,
   parameter logic [CNT_W-1:0] STABLE_CYC = CNT_W'(`FPM_DEBOUNCE_MS * `FPM_CLK_KHZ)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // buttons
   input wire logic [N-1:0] raw,
   output logic [N-1:0] level,
   output logic [N-1:0] press
);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_btn
         logic s1_r, s2_r, lvl_r, lvl_nxt, prs_r, prs_nxt;
         logic [CNT_W-1:0] cnt_r, cnt_nxt;
         always_comb begin
            lvl_nxt = lvl_r;
            prs_nxt = 1'b0;
            cnt_nxt = '0;
            if (s2_r != lvl_r) begin // [R25]
               cnt_nxt = cnt_r + CNT_W'(1);
               if (cnt_r >= STABLE_CYC - CNT_W'(1)) begin
                  lvl_nxt = s2_r;
                  prs_nxt = s2_r;
                  cnt_nxt = '0;
               end
            end
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               lvl_r <= 1'b0;
               prs_r <= 1'b0;
               cnt_r <= '0;
            end else begin
               s1_r <= raw[g];
               s2_r <= s1_r;
               lvl_r <= lvl_nxt;
               prs_r <= prs_nxt;
               cnt_r <= cnt_nxt;
            end
         end
         assign level[g] = lvl_r;
         assign press[g] = prs_r;
         a_press_pulse: assert property (@(posedge clk) disable iff (!rst_b) // [R25]
            press[g] |-> level[g] ##1 !press[g])
            else $error("press pulse wrong");
      end
   endgenerate
endmodule : fpm_debounce

/* File: logic/fpm_menu_ctrl.sv */
/*
 Front panel menu controller: power-up sequence, display-mode buttons,
 code-guarded menu, per-item settings and readout scaling.
 Assumes active-low push-button pins, a microamp input sample each cycle,
 stored calibration and code supplied from non-volatile memory outside.
*/
// How it works
// (R1) every power-up (reset) starts the initialisation sequence
// (R2) short delay, 0.5 s blank, 3 s circulating minus, then readout
// (R3) function held shows mA or percent of span, else engineering units
// (R4) with an alarm enabled function held shows the alarm setpoint instead
// (R5) down held shows the value calibrated for 4mA
// (R6) up held shows the value calibrated for 20mA
// (R7) quit alone in display mode changes nothing
// (R8) function plus quit together is the only way into the menu
// (R9) without a code the menu opens on the square-root item
// (R10) with a code not 0000 the lock prompt shows first
// (R11) function clears prompt; up, down, function edit the code digits
// (R12) quit with the right code opens the menu on the first item
// (R13) quit with a wrong or absent code returns to display mode
// (R14) up and down step through the menu items
// (R15) leaving after changes shows minus signs while settings are stored
// (R16) without calibration 4 to 20mA reads 0.00 to 100.00
// (R17) square-root flag linearises the input
// (R18) numeric readout flag turns the digits on or off
// (R19) step size picks a last-digit increment of 1, 2, 5 or 10
// (R20) padding flag appends a fixed zero digit
// (R21) radix point sits between any digit pair or is off
// (R22) bar style picks column or segment, single or dual bargraph
// (R23) the code is four decimal digits guarding every setting
// (R24) in an item quit returns to the list, up and down change it
// (R25) buttons are debounced, function and quit paired when both are held in a window that a press of either opens
// (R26) the input sample is scaled with the settings every cycle
`include "fpm_map.svh"
module fpm_menu_ctrl
   import fpm_pkg::*;
#(
   parameter int CNT_W = 27,
   parameter logic [CNT_W-1:0] INIT_CYC = CNT_W'(`FPM_INIT_MS * `FPM_CLK_KHZ),
   parameter logic [CNT_W-1:0] BLANK_CYC = CNT_W'(`FPM_BLANK_MS * `FPM_CLK_KHZ),
   parameter logic [CNT_W-1:0] MINUS_CYC = CNT_W'(`FPM_MINUS_MS * `FPM_CLK_KHZ),
   parameter logic [CNT_W-1:0] SAVE_CYC = CNT_W'(`FPM_SAVE_MS * `FPM_CLK_KHZ),
   parameter logic [CNT_W-1:0] COMBO_CYC = CNT_W'(`FPM_COMBO_MS * `FPM_CLK_KHZ),
   parameter int DB_W = 18,
   parameter logic [DB_W-1:0] DB_CYC = DB_W'(`FPM_DEBOUNCE_MS * `FPM_CLK_KHZ)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // push-button pins
   input wire logic fn_button_b,
   input wire logic quit_button_b,
   input wire logic up_button_b,
   input wire logic down_button_b,
   // measurement and stored data
   input wire logic [15:0] sample_ua,
   input wire logic cal_valid,
   input wire logic signed [17:0] cal_lo_val,
   input wire logic signed [17:0] cal_hi_val,
   input wire logic [15:0] stored_code,
   input wire logic fn_shows_pct,
   input wire logic alarm_enabled,
   input wire logic signed [17:0] alarm_setpoint,
   // readout
   output logic signed [17:0] readout_value,
   output logic readout_blank,
   output logic minus_anim,
   output fpm_show_t show_sel,
   output fpm_item_t menu_item,
   output logic [15:0] code_keyed,
   output logic [1:0] code_digit,
   // settings
   output logic sqrt_linearise,
   output logic numeric_readout_on,
   output fpm_step_t step_size,
   output logic padding_digit_on,
   output logic [2:0] radix_point_place,
   output logic column_style,
   output logic dual_bars,
   output logic bar_page,
   output logic settings_store
);
   // ----------------------------------------
   // buttons
   // ----------------------------------------
   logic [3:0] lvl, prs;
   logic fn_l, q_l, up_l, dn_l, fn_p, q_p, up_p, dn_p;

   fpm_debounce #(.N(4), .CNT_W(DB_W), .STABLE_CYC(DB_CYC)) u_db (
      .clk(clk),
      .rst_b(rst_b),
      .raw({~down_button_b, ~up_button_b, ~quit_button_b, ~fn_button_b}),
      .level(lvl),
      .press(prs)
   );
   assign {dn_l, up_l, q_l, fn_l} = lvl;
   assign {dn_p, up_p, q_p, fn_p} = prs;

   // a pair counts once both are held while the window runs; a press of either opens the window when it is idle
   logic [CNT_W-1:0] win_r, win_nxt;
   logic seen_r, seen_nxt, combo_ev;
   always_comb begin
      combo_ev = fn_l && q_l && !seen_r && win_r != '0; // [R25]
      win_nxt = win_r;
      if ((fn_p || q_p) && win_r == '0)
         win_nxt = COMBO_CYC;
      else if (win_r != '0)
         win_nxt = win_r - CNT_W'(1);
      seen_nxt = seen_r;
      if (combo_ev)
         seen_nxt = 1'b1;
      else if (!fn_l && !q_l)
         seen_nxt = 1'b0;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         win_r <= '0;
         seen_r <= 1'b0;
      end else begin
         win_r <= win_nxt;
         seen_r <= seen_nxt;
      end
   end

   // ----------------------------------------
   // sequencer and settings
   // ----------------------------------------
   fpm_state_t st_r, st_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt;
   fpm_item_t item_r, item_nxt;
   logic [15:0] key_r, key_nxt;
   logic [1:0] dig_r, dig_nxt;
   logic dirty_r, dirty_nxt, page_r, page_nxt, save_r, save_nxt;
   logic sqrt_r, sqrt_nxt, num_r, num_nxt, pad_r, pad_nxt, col_r, col_nxt, dual_r, dual_nxt;
   fpm_step_t step_r, step_nxt;
   logic [2:0] dp_r, dp_nxt;
   logic [3:0] cur_dig;
   logic chg;

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = (tmr_r != '0) ? tmr_r - CNT_W'(1) : tmr_r;
      item_nxt = item_r;
      key_nxt = key_r;
      dig_nxt = dig_r;
      dirty_nxt = dirty_r;
      page_nxt = page_r;
      save_nxt = 1'b0;
      sqrt_nxt = sqrt_r;
      num_nxt = num_r;
      pad_nxt = pad_r;
      col_nxt = col_r;
      dual_nxt = dual_r;
      step_nxt = step_r;
      dp_nxt = dp_r;
      cur_dig = key_r[4*dig_r +: 4];
      chg = up_p || dn_p;
      case (st_r)
         FPM_ST_INIT: if (tmr_r == '0) begin // [R1]
            st_nxt = FPM_ST_BLANK;
            tmr_nxt = BLANK_CYC - CNT_W'(1);
         end
         FPM_ST_BLANK: if (tmr_r == '0) begin // [R2]
            st_nxt = FPM_ST_MINUS;
            tmr_nxt = MINUS_CYC - CNT_W'(1);
         end
         FPM_ST_MINUS: if (tmr_r == '0)
            st_nxt = FPM_ST_DISPLAY; // [R2]
         FPM_ST_DISPLAY: if (combo_ev) begin // [R8] [R7]
            item_nxt = FPM_IT_ROOT;
            dirty_nxt = 1'b0;
            st_nxt = (stored_code == `FPM_DEF_CODE) ? FPM_ST_MENU : FPM_ST_LOCK; // [R9] [R10]
         end
         FPM_ST_LOCK: if (fn_p) begin // [R11]
            st_nxt = FPM_ST_CODE;
            key_nxt = '0;
            dig_nxt = '0;
         end else if (q_p)
            st_nxt = FPM_ST_DISPLAY; // [R13]
         FPM_ST_CODE: begin
            if (up_p) // [R11] [R23]
               cur_dig = (cur_dig >= `FPM_BCD_MAX) ? 4'h0 : cur_dig + 4'h1;
            else if (dn_p)
               cur_dig = (cur_dig == 4'h0) ? `FPM_BCD_MAX : cur_dig - 4'h1;
            key_nxt[4*dig_r +: 4] = cur_dig;
            if (fn_p)
               dig_nxt = (dig_r == `FPM_LAST_DIGIT) ? 2'h0 : dig_r + 2'h1;
            if (q_p)
               st_nxt = (key_r == stored_code) ? FPM_ST_MENU : FPM_ST_DISPLAY; // [R12] [R13]
         end
         FPM_ST_MENU: begin
            if (up_p) // [R14]
               item_nxt = (item_r == `FPM_LAST_ITEM) ? FPM_IT_ROOT : fpm_item_t'(item_r + 3'h1);
            else if (dn_p)
               item_nxt = (item_r == FPM_IT_ROOT) ? fpm_item_t'(`FPM_LAST_ITEM) : fpm_item_t'(item_r - 3'h1);
            if (fn_p) begin
               st_nxt = FPM_ST_ITEM;
               page_nxt = 1'b0;
            end else if (q_p) begin
               st_nxt = dirty_r ? FPM_ST_SAVE : FPM_ST_DISPLAY; // [R15]
               save_nxt = dirty_r;
               tmr_nxt = SAVE_CYC - CNT_W'(1);
            end
         end
         FPM_ST_ITEM: begin
            if (q_p)
               st_nxt = FPM_ST_MENU; // [R24]
            else if (chg) begin
               dirty_nxt = 1'b1;
               case (item_r) // [R24]
                  FPM_IT_ROOT: sqrt_nxt = !sqrt_r; // [R17]
                  FPM_IT_NUM: num_nxt = !num_r; // [R18]
                  FPM_IT_STEP: step_nxt = up_p ? fpm_step_t'(step_r + 2'h1) : fpm_step_t'(step_r - 2'h1); // [R19]
                  FPM_IT_PAD: pad_nxt = !pad_r; // [R20]
                  FPM_IT_DP: // [R21]
                     if (up_p)
                        dp_nxt = (dp_r >= `FPM_DP_MAX) ? 3'h0 : dp_r + 3'h1;
                     else
                        dp_nxt = (dp_r == 3'h0) ? `FPM_DP_MAX : dp_r - 3'h1;
                  FPM_IT_BAR: // [R22]
                     if (page_r)
                        dual_nxt = !dual_r;
                     else
                        col_nxt = !col_r;
                  default: dirty_nxt = dirty_r;
               endcase
            end else if (fn_p && item_r == FPM_IT_BAR)
               page_nxt = !page_r; // [R22]
         end
         FPM_ST_SAVE: if (tmr_r == '0)
            st_nxt = FPM_ST_DISPLAY; // [R15]
         default: st_nxt = FPM_ST_INIT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= FPM_ST_INIT; // [R1]
         tmr_r <= INIT_CYC;
         item_r <= FPM_IT_ROOT;
         key_r <= '0;
         dig_r <= '0;
         dirty_r <= 1'b0;
         page_r <= 1'b0;
         save_r <= 1'b0;
         sqrt_r <= 1'b0;
         num_r <= 1'b1;
         pad_r <= 1'b0;
         col_r <= 1'b1;
         dual_r <= 1'b0;
         step_r <= FPM_STEP_1;
         dp_r <= 3'h3;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         item_r <= item_nxt;
         key_r <= key_nxt;
         dig_r <= dig_nxt;
         dirty_r <= dirty_nxt;
         page_r <= page_nxt;
         save_r <= save_nxt;
         sqrt_r <= sqrt_nxt;
         num_r <= num_nxt;
         pad_r <= pad_nxt;
         col_r <= col_nxt;
         dual_r <= dual_nxt;
         step_r <= step_nxt;
         dp_r <= dp_nxt;
      end
   end

   // ----------------------------------------
   // readout datapath
   // ----------------------------------------
   function automatic logic [15:0] isqrt(input logic [31:0] v);
      logic [31:0] rem;
      logic [15:0] root;
      logic [17:0] trial;
      rem = '0;
      root = '0;
      for (int i = 15; i >= 0; i--) begin
         rem = {rem[29:0], v[2*i +: 2]};
         trial = {root, 2'b01};
         root = {root[14:0], 1'b0};
         if (rem >= 32'(trial)) begin
            rem = rem - 32'(trial);
            root[0] = 1'b1;
         end
      end
      return root;
   endfunction : isqrt

   logic signed [17:0] val_r, val_nxt, lo, hi, x, lin, eng, stp;
   logic signed [35:0] prod;
   logic blank_r, blank_nxt, minus_r, minus_nxt;
   fpm_show_t show_r, show_nxt;

   always_comb begin
      lo = cal_valid ? cal_lo_val : `FPM_DEF_LO; // [R16]
      hi = cal_valid ? cal_hi_val : `FPM_DEF_HI;
      x = $signed({2'b00, sample_ua}) - `FPM_UA_4MA; // [R26]
      lin = x;
      if (sqrt_r) // [R17]
         lin = (x < `FPM_UA_ROOT_MIN) ? 18'sh0 : $signed({2'b00, isqrt(32'(x) * 32'(`FPM_UA_SPAN))});
      prod = 36'(hi - lo) * 36'(lin);
      eng = lo + 18'(prod / 36'(`FPM_UA_SPAN));
      case (step_r) // [R19]
         FPM_STEP_2: stp = 18'sh2;
         FPM_STEP_5: stp = 18'sh5;
         FPM_STEP_10: stp = 18'shA;
         default: stp = 18'sh1;
      endcase
      eng = (eng / stp) * stp;
      val_nxt = eng;
      if (up_l)
         val_nxt = hi; // [R6]
      else if (dn_l)
         val_nxt = lo; // [R5]
      else if (fn_l && alarm_enabled)
         val_nxt = alarm_setpoint; // [R4]
      else if (fn_l)
         val_nxt = fn_shows_pct ? 18'((x * 18'sh5) >>> 3) : x / `FPM_UA_PER_CA + 18'sh190; // [R3]
      if (st_r != FPM_ST_DISPLAY)
         val_nxt = val_r;
      blank_nxt = st_r != FPM_ST_DISPLAY || !num_r; // [R2] [R18]
      minus_nxt = st_r == FPM_ST_MINUS || st_r == FPM_ST_SAVE; // [R2] [R15]
      case (st_r)
         FPM_ST_LOCK: show_nxt = FPM_SHOW_LOCK; // [R10]
         FPM_ST_CODE: show_nxt = FPM_SHOW_CODE;
         FPM_ST_MENU, FPM_ST_ITEM: show_nxt = FPM_SHOW_MENU;
         default: show_nxt = FPM_SHOW_VALUE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         val_r <= '0;
         blank_r <= 1'b1;
         minus_r <= 1'b0;
         show_r <= FPM_SHOW_VALUE;
      end else begin
         val_r <= val_nxt;
         blank_r <= blank_nxt;
         minus_r <= minus_nxt;
         show_r <= show_nxt;
      end
   end

   assign readout_value = val_r;
   assign readout_blank = blank_r;
   assign minus_anim = minus_r;
   assign show_sel = show_r;
   assign menu_item = item_r;
   assign code_keyed = key_r;
   assign code_digit = dig_r;
   assign sqrt_linearise = sqrt_r;
   assign numeric_readout_on = num_r;
   assign step_size = step_r;
   assign padding_digit_on = pad_r;
   assign radix_point_place = dp_r;
   assign column_style = col_r;
   assign dual_bars = dual_r;
   assign bar_page = page_r;
   assign settings_store = save_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_blank_to_minus: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      st_r == FPM_ST_BLANK && tmr_r == '0 |=> st_r == FPM_ST_MINUS && tmr_r == MINUS_CYC - CNT_W'(1))
      else $error("blank phase did not hand over");
   a_menu_only_combo: assert property (@(posedge clk) disable iff (!rst_b) // [R8] [R7]
      st_r == FPM_ST_DISPLAY && !combo_ev |=> st_r == FPM_ST_DISPLAY && $stable(item_r))
      else $error("left display without pair");
   a_open_unlocked: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
      st_r == FPM_ST_DISPLAY && combo_ev && stored_code == `FPM_DEF_CODE
      |=> st_r == FPM_ST_MENU && item_r == FPM_IT_ROOT ##1 show_r == FPM_SHOW_MENU)
      else $error("menu not opened on first item");
   a_open_locked: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
      st_r == FPM_ST_DISPLAY && combo_ev && stored_code != `FPM_DEF_CODE
      |=> st_r == FPM_ST_LOCK ##1 show_r == FPM_SHOW_LOCK)
      else $error("lock prompt missing");
   a_code_check: assert property (@(posedge clk) disable iff (!rst_b) // [R12] [R13]
      st_r == FPM_ST_CODE && q_p |=> st_r == ($past(key_r) == $past(stored_code) ? FPM_ST_MENU : FPM_ST_DISPLAY))
      else $error("code verdict wrong");
   a_hold_down: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
      st_r == FPM_ST_DISPLAY && dn_l && !up_l |=> val_r == $past(lo))
      else $error("4mA value not shown");
   a_hold_up: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
      st_r == FPM_ST_DISPLAY && up_l |=> val_r == $past(hi))
      else $error("20mA value not shown");
   a_save_seq: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
      st_r == FPM_ST_MENU && q_p && !fn_p && dirty_r |=> st_r == FPM_ST_SAVE && settings_store ##1 minus_anim)
      else $error("store sequence missing");
   a_menu_step: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
      st_r == FPM_ST_MENU && up_p && item_r == FPM_IT_ROOT |=> item_r == FPM_IT_NUM)
      else $error("menu step wrong");
endmodule : fpm_menu_ctrl

/* File: sim/fpm_operator.sv */
/* operator model: four active-low front panel buttons with contact bounce.
 assumes pins are pulled up while released; changes at the falling edge. */
module fpm_operator (
   // clock
   input wire logic clk,
   // held buttons: fn, quit, up, down
   input wire logic [3:0] hold,
   // pins, low while pressed
   output logic [3:0] pins_b = 4'hF
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph [4] = '{default: 2'h0};
   // one bounce cycle after contact, shorter than the debounce window
   always @(negedge clk) begin
      for (int i = 0; i < 4; i++) begin
         ph[i] <= hold[i] ? ((ph[i] == 2'h3) ? 2'h3 : ph[i] + 2'h1) : 2'h0;
         pins_b[i] <= !(hold[i] && ph[i] != 2'h1);
      end
   end
endmodule : fpm_operator

/* File: sim/test_front_panel_menu_controller.sv */
/* self-checking bench of the front panel menu controller.
 assumes shortened counts and the operator model on the button pins. */
module test_front_panel_menu_controller;
   import fpm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // stimulus and wiring
   // ------------------------------
   localparam int DB = 3;
   localparam int MIN = 20;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] hold = 4'h0;
   logic [3:0] pins_b;
   logic [15:0] sample_ua = 16'h0FA0;
   logic cal_valid = 1'b0;
   logic signed [17:0] cal_lo_val;
   logic signed [17:0] cal_hi_val;
   logic [15:0] stored_code = 16'h0000;
   logic fn_shows_pct = 1'b0;
   logic alarm_enabled = 1'b0;
   logic signed [17:0] alarm_setpoint;
   logic signed [17:0] readout_value;
   logic readout_blank, minus_anim, sqrt_linearise, numeric_readout_on, padding_digit_on;
   logic column_style, dual_bars, settings_store, bar_page;
   fpm_show_t show_sel;
   fpm_item_t menu_item;
   fpm_step_t step_size;
   logic [15:0] code_keyed;
   logic [1:0] code_digit;
   logic [2:0] radix_point_place;
   int bad_count = 0;
   int tests_run = 0;
   int k;
   int s;
   logic [31:0] rnd = 32'h2AF1A746;
   always #25 clk = ~clk;
   fpm_operator i_op (.clk(clk), .hold(hold), .pins_b(pins_b));
   fpm_menu_ctrl #(.INIT_CYC(27'h5), .BLANK_CYC(27'hA), .MINUS_CYC(27'h14), .SAVE_CYC(27'hA),
      .DB_CYC(18'h3)) i_dut (.clk(clk), .rst_b(rst_b),
      .fn_button_b(pins_b[0]), .quit_button_b(pins_b[1]), .up_button_b(pins_b[2]),
      .down_button_b(pins_b[3]), .sample_ua(sample_ua), .cal_valid(cal_valid), .cal_lo_val(cal_lo_val),
      .cal_hi_val(cal_hi_val), .stored_code(stored_code), .fn_shows_pct(fn_shows_pct),
      .alarm_enabled(alarm_enabled), .alarm_setpoint(alarm_setpoint), .readout_value(readout_value),
      .readout_blank(readout_blank), .minus_anim(minus_anim), .show_sel(show_sel), .menu_item(menu_item),
      .code_keyed(code_keyed), .code_digit(code_digit), .sqrt_linearise(sqrt_linearise),
      .numeric_readout_on(numeric_readout_on), .step_size(step_size), .padding_digit_on(padding_digit_on),
      .radix_point_place(radix_point_place), .column_style(column_style), .dual_bars(dual_bars),
      .bar_page(bar_page), .settings_store(settings_store));
   // ------------------------------
   // expectations and helpers
   // ------------------------------
   function automatic logic [31:0] nx(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nx
   function automatic int isq(int v);
      int r = 0;
      while ((r + 1) * (r + 1) <= v) r++;
      return r;
   endfunction : isq
   function automatic int eng(int v, int lo, int hi, bit sq, int st);
      int lin = v - 4000;
      if (sq) lin = (lin < 40) ? 0 : isq(lin * 16000);
      lin = lo + (hi - lo) * lin / 16000;
      return lin / st * st;
   endfunction : eng
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic check(string nm, logic [17:0] e, logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask : check
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic bound(int lim);
      if (k >= lim) begin
         bad_count++;
         summarize();
      end
   endtask : bound
   task automatic press(logic [3:0] m);
      hold <= m;
      tick(DB + 8);
      hold <= 4'h0;
      tick(DB + 8);
   endtask : press
   task automatic read(int v, int e);
      sample_ua = 16'(v);
      tick(3);
      check("readout", 18'(e), readout_value);
   endtask : read
   task automatic rand_s;
      rnd = nx(rnd);
      s = 4000 + int'(rnd % 32'd16001);
   endtask : rand_s
   task automatic powerup;
      rst_b = 1'b0;
      tick(5);
      check("rst", 18'h90E, {readout_blank, minus_anim, sqrt_linearise, numeric_readout_on, step_size,
         padding_digit_on, radix_point_place, column_style, dual_bars});
      rst_b = 1'b1;
      for (k = 0; k < 200 && minus_anim !== 1'b1; k++) tick(1);
      bound(200);
      check("blank_len", 18'h1, 18'(k >= 15));
      for (k = 0; k < 200 && minus_anim === 1'b1; k++) tick(1);
      check("minus_len", 18'(MIN), 18'(k));
      tick(3);
      check("shown", 18'h0, {readout_blank, show_sel});
   endtask : powerup
   // walk to an item, change it once, or twice when two is set
   task automatic menu_set(fpm_item_t it, bit two);
      for (k = 0; k < 8 && menu_item !== it; k++) press(4'h4);
      bound(8);
      press(4'h1);
      press(4'h4);
      if (two) begin
         press(4'h1);
         press(4'h4);
      end
      press(4'h2);
      check("back_list", 18'h3, 18'(show_sel));
   endtask : menu_set
   task automatic leave_save;
      hold <= 4'h2;
      for (k = 0; k < 60 && settings_store !== 1'b1; k++) tick(1);
      bound(60);
      tick(2);
      check("store_anim", 18'h1, 18'(minus_anim));
      hold <= 4'h0;
      for (k = 0; k < 100 && minus_anim !== 1'b0; k++) tick(1);
      bound(100);
      tick(2);
   endtask : leave_save
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      powerup();
      read(4000, 0);
      read(20000, 10000);
      repeat (4) begin
         rand_s();
         read(s, eng(s, 0, 10000, 0, 1));
      end
      rnd = nx(rnd);
      cal_lo_val = 18'(rnd[11:0]);
      cal_hi_val = 18'(rnd[27:14]);
      alarm_setpoint = 18'(rnd[31:19]);
      cal_valid = 1'b1;
      repeat (4) begin
         rand_s();
         read(s, eng(s, cal_lo_val, cal_hi_val, 0, 1));
      end
      sample_ua = 16'h2EE0;
      hold <= 4'h8;
      tick(DB + 8);
      check("down", cal_lo_val, readout_value);
      hold <= 4'hC;
      tick(DB + 8);
      check("up", cal_hi_val, readout_value);
      hold <= 4'h1;
      tick(DB + 8);
      check("fn_ma", 18'd1200, readout_value);
      fn_shows_pct = 1'b1;
      tick(3);
      check("fn_pct", 18'd5000, readout_value);
      alarm_enabled = 1'b1;
      tick(3);
      check("fn_alarm", alarm_setpoint, readout_value);
      hold <= 4'h0;
      alarm_enabled = 1'b0;
      tick(DB + 8);
      check("release", 18'(eng(12000, cal_lo_val, cal_hi_val, 0, 1)), readout_value);
      hold <= 4'h2;
      tick(DB + 8);
      check("quit_only", 18'h0, {readout_blank, show_sel});
      check("quit_val", 18'(eng(12000, cal_lo_val, cal_hi_val, 0, 1)), readout_value);
      hold <= 4'h0;
      cal_valid = 1'b0;
      tick(DB + 8);
      press(4'h3);
      check("menu_in", 18'h3, 18'(show_sel));
      check("first", 18'(FPM_IT_ROOT), 18'(menu_item));
      press(4'h8);
      check("wrap", 18'(FPM_IT_BAR), 18'(menu_item));
      press(4'h4);
      menu_set(FPM_IT_ROOT, 1'b0);
      menu_set(FPM_IT_STEP, 1'b0);
      check("root", 18'h1, 18'(sqrt_linearise));
      check("step", 18'(FPM_STEP_2), 18'(step_size));
      leave_save();
      read(8000, eng(8000, 0, 10000, 1, 2));
      read(4020, 0);
      repeat (4) begin
         rand_s();
         read(s, eng(s, 0, 10000, 1, 2));
      end
      press(4'h3);
      menu_set(FPM_IT_NUM, 1'b0);
      menu_set(FPM_IT_STEP, 1'b1);
      menu_set(FPM_IT_PAD, 1'b0);
      menu_set(FPM_IT_DP, 1'b0);
      menu_set(FPM_IT_BAR, 1'b1);
      leave_save();
      read(4200, eng(4200, 0, 10000, 1, 10));
      check("page", 18'h1, 18'(bar_page));
      check("numeric", 18'h1, {numeric_readout_on, readout_blank});
      check("pad", 18'h1, 18'(padding_digit_on));
      check("radix", 18'h4, 18'(radix_point_place));
      check("bar", 18'h1, {column_style, dual_bars});
      stored_code = 16'h0012;
      press(4'h3);
      check("lock", 18'h1, 18'(show_sel));
      press(4'h1);
      check("code", 18'h2, {code_keyed, show_sel});
      press(4'h4);
      press(4'h4);
      press(4'h1);
      check("digit", 18'h1, 18'(code_digit));
      press(4'h4);
      check("keyed", 18'h0012, 18'(code_keyed));
      press(4'h2);
      check("unlock", 18'h3, 18'(show_sel));
      press(4'h2);
      tick(30);
      press(4'h3);
      press(4'h1);
      press(4'h4);
      press(4'h2);
      check("wrong", 18'h0, 18'(show_sel));
      press(4'h3);
      press(4'h2);
      check("none", 18'h0, 18'(show_sel));
      powerup();
      summarize();
   end
   initial begin
      #(50 * 100000);
      bad_count++;
      summarize();
   end
endmodule : test_front_panel_menu_controller
